/* cvf_consts.vh */
// constants for the cell voltage fault block
`ifndef CVF_CONSTS_VH
`define CVF_CONSTS_VH

// register indices, byte address is four times the index
`define CVF_IDX_OV_TRIP 8'h02
`define CVF_IDX_OV_CFG 8'h03
`define CVF_IDX_UV_THR 8'h04
`define CVF_IDX_UNDERVOLT_RECOVERY_MODE 8'h05
`define CVF_IDX_STATUS 8'h10

// overvolt_hysteresis_delay_config fields
`define CVF_OV_PULL_BIT 7
`define CVF_OV_HYST_MSB 6
`define CVF_OV_HYST_LSB 4
`define CVF_OV_DLY_MSB 2
`define CVF_OV_DLY_LSB 0
// undervolt_threshold_config fields
`define CVF_UV_BYPASS_BIT 7
`define CVF_UV_TRIP_MSB 3
`define CVF_UV_TRIP_LSB 0
// undervolt_recovery_config fields
`define CVF_UV_MODE_BIT 7
`define CVF_UV_SD_BIT 6
`define CVF_UV_HYST_MSB 5
`define CVF_UV_HYST_LSB 4
`define CVF_UV_DLY_MSB 2
`define CVF_UV_DLY_LSB 0

// reset values and write masks
`define CVF_RST_OV_TRIP 8'h00
`define CVF_RST_OV_CFG 8'h00
`define CVF_RST_UV_THR 8'h00
`define CVF_RST_UNDERVOLT_RECOVERY_MODE 8'h00
`define CVF_MASK_OV_TRIP 8'h3f
`define CVF_MASK_OV_CFG 8'hf7
`define CVF_MASK_UV_THR 8'h8f
`define CVF_MASK_UNDERVOLT_RECOVERY_MODE 8'hf7

// voltages in millivolts, and the undervoltage delay code meaning off
`define CVF_OV_BASE_MV 13'h0af0
`define CVF_OV_STEP_MV 13'h0019
`define CVF_UV_BASE_MV 13'h0578
`define CVF_UV_STEP_MV 13'h0064
`define CVF_UV_HYST_STEP_MV 13'h0190
`define CVF_UNDERVOLT_RECOVERY_MODE_MAX_MV 13'h0dac
`define CVF_UV_DLY_OFF 3'h7

// timing: one tick is a quarter second
`define CVF_CLK_MHZ 200
`define CVF_TICK_MS 250
`define CVF_TICK_CYCLES (`CVF_TICK_MS * 1000 * `CVF_CLK_MHZ)
`define CVF_OV_DLY_BASE_TICKS 8'h02
`define CVF_UV_DLY_BASE_TICKS 8'h02
`define CVF_SD_TICKS 8'h20

`define CVF_CELLS 10
`define CVF_MV_W 13

`endif

/* cvf_delay_timer.v */
// delay timer counting quarter-second ticks while its condition holds
`timescale 1ns/1ps
`include "cvf_consts.vh"
module cvf_delay_timer #(
    parameter [31:0] TICK_CYCLES = `CVF_TICK_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire [7:0] target,
    output wire expired
);
    reg [31:0] cyc_r;
    reg [7:0] ticks_r;

    // restarts whenever the condition drops
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            cyc_r <= 32'h0000_0000;
            ticks_r <= 8'h00;
        end else if (ticks_r != target) begin
            if (cyc_r == TICK_CYCLES - 32'h0000_0001) begin
                cyc_r <= 32'h0000_0000;
                ticks_r <= ticks_r + 8'h01;
            end else begin
                cyc_r <= cyc_r + 32'h0000_0001;
            end
        end
    end

    assign expired = run && (ticks_r == target);
endmodule

/* cvf_cell_compare.v */
// compares the enabled cells against one threshold
`timescale 1ns/1ps
`include "cvf_consts.vh"
module cvf_cell_compare (
    input wire [`CVF_CELLS*`CVF_MV_W-1:0] cell_mv,
    input wire [`CVF_CELLS-1:0] cell_enable,
    input wire [`CVF_MV_W-1:0] threshold,
    output reg any_above,
    output reg all_above,
    output reg any_below,
    output reg all_below
);
    integer i;
    reg [`CVF_MV_W-1:0] v;

    always @* begin
        v = {`CVF_MV_W{1'b0}};
        any_above = 1'b0;
        all_above = 1'b1;
        any_below = 1'b0;
        all_below = 1'b1;
        for (i = 0; i < `CVF_CELLS; i = i + 1) begin
            v = cell_mv[i*`CVF_MV_W +: `CVF_MV_W];
            if (cell_enable[i]) begin
                if (v > threshold) begin
                    any_above = 1'b1;
                end else begin
                    all_above = 1'b0;
                end
                if (v < threshold) begin
                    any_below = 1'b1;
                end else begin
                    all_below = 1'b0;
                end
            end
        end
    end
endmodule

/* cvf_fault_core.v */
// cell over and undervoltage fault logic with its register slave
// Functional notes
// R1 - pull bit 1: thermistor line pulled low on overvoltage; 0: line left alone
// R2 - overvoltage hysteresis codes 0..7 give 300,250,200,150,100,50,25,0 mV
// R3 - overvoltage delay is 0.50 s plus 0.25 s per code
// R4 - bypass bit 1: recovery level is the trip level without hysteresis
// R5 - undervoltage trip is 1.4 V plus 0.1 V per code
// R6 - mode 0: recover when all cells exceed recovery level, charge switch at once
// R7 - mode 1: recovery also waits for the load to be removed
// R8 - shutdown enable 0: never shut down from undervoltage fault
// R9 - shutdown enable 1: shut down if a cell stays low over 8 s in fault
// R10 - undervoltage hysteresis codes 0..3 give 0.4,0.8,1.2,1.6 V
// R11 - recovery level is trip plus hysteresis, clamped at 3.5 V
// R12 - undervoltage delay 0.5 s doubling per code, code 7 means off
// R13 - overvoltage trip 2.800 V plus 25 mV per code
// R14 - overvoltage fault after full delay above trip; clears below trip minus hysteresis
// R15 - undervoltage fault after full delay below trip; timer restarts if it clears
// R16 - reserved bits have no effect and read as zero
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cvf_consts.vh"
module cvf_fault_core #(
    parameter [31:0] TICK_CYCLES = `CVF_TICK_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axil_awaddr,
    input wire s_axil_awvalid,
    output wire s_axil_awready,
    input wire [31:0] s_axil_wdata,
    input wire [3:0] s_axil_wstrb,
    input wire s_axil_wvalid,
    output wire s_axil_wready,
    output reg [1:0] s_axil_bresp,
    output reg s_axil_bvalid,
    input wire s_axil_bready,
    input wire [31:0] s_axil_araddr,
    input wire s_axil_arvalid,
    output wire s_axil_arready,
    output reg [31:0] s_axil_rdata,
    output reg [1:0] s_axil_rresp,
    output reg s_axil_rvalid,
    input wire s_axil_rready,
    input wire [`CVF_CELLS*`CVF_MV_W-1:0] cell_mv,
    input wire [`CVF_CELLS-1:0] cell_enable,
    input wire charger_present,
    input wire load_present,
    output reg overvolt_fault,
    output reg undervolt_fault,
    output reg shutdown_req,
    output reg charge_switch_en,
    output reg discharge_switch_en,
    input wire thermistor_line_i,
    output wire thermistor_line_o,
    output reg thermistor_line_oe
);
    // ==========
    // helper functions
    function [7:0] addr_idx;
        input [31:0] addr;
        begin
            addr_idx = addr[9:2];
        end
    endfunction

    function addr_hit;
        input [31:0] addr;
        begin
            addr_hit = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h00_0000);
        end
    endfunction

    function [`CVF_MV_W-1:0] ov_trip_mv;
        input [5:0] code;
        begin
            ov_trip_mv = `CVF_OV_BASE_MV + {7'h00, code} * `CVF_OV_STEP_MV; // R13
        end
    endfunction

    function [`CVF_MV_W-1:0] ov_hyst_mv;
        input [2:0] code;
        begin
            case (code) // R2
                3'h0: ov_hyst_mv = 13'h012c;
                3'h1: ov_hyst_mv = 13'h00fa;
                3'h2: ov_hyst_mv = 13'h00c8;
                3'h3: ov_hyst_mv = 13'h0096;
                3'h4: ov_hyst_mv = 13'h0064;
                3'h5: ov_hyst_mv = 13'h0032;
                3'h6: ov_hyst_mv = 13'h0019;
                default: ov_hyst_mv = 13'h0000;
            endcase
        end
    endfunction

    function [`CVF_MV_W-1:0] uv_trip_mv;
        input [3:0] code;
        begin
            uv_trip_mv = `CVF_UV_BASE_MV + {9'h000, code} * `CVF_UV_STEP_MV; // R5
        end
    endfunction

    function [`CVF_MV_W-1:0] uv_hyst_mv;
        input [1:0] code;
        begin
            uv_hyst_mv = ({11'h000, code} + 13'h0001) * `CVF_UV_HYST_STEP_MV; // R10
        end
    endfunction

    // ==========
    // configuration registers
    reg [7:0] ov_trip_r;
    reg [7:0] ov_cfg_r;
    reg [7:0] uv_thr_r;
    reg [7:0] undervolt_recovery_mode_r;

    // ==========
    // axi4-lite write channel
    reg aw_got_r;
    reg w_got_r;
    reg [31:0] awaddr_r;
    reg [31:0] wdata_r;
    reg wstrb0_r;
    wire do_write;
    reg wr_known;

    assign s_axil_awready = !aw_got_r && !s_axil_bvalid;
    assign s_axil_wready = !w_got_r && !s_axil_bvalid;
    assign do_write = aw_got_r && w_got_r && !s_axil_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb0_r <= 1'b0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= 2'b00;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axil_wdata;
                wstrb0_r <= s_axil_wstrb[0];
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= wr_known ? 2'b00 : 2'b10;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        wr_known = 1'b0;
        if (addr_hit(awaddr_r)) begin
            case (addr_idx(awaddr_r))
                `CVF_IDX_OV_TRIP: wr_known = 1'b1;
                `CVF_IDX_OV_CFG: wr_known = 1'b1;
                `CVF_IDX_UV_THR: wr_known = 1'b1;
                `CVF_IDX_UNDERVOLT_RECOVERY_MODE: wr_known = 1'b1;
                `CVF_IDX_STATUS: wr_known = 1'b1;
                default: wr_known = 1'b0;
            endcase
        end
    end

    // reserved bits are never stored
    always @(posedge aclk) begin
        if (!aresetn) begin
            ov_trip_r <= `CVF_RST_OV_TRIP;
            ov_cfg_r <= `CVF_RST_OV_CFG;
            uv_thr_r <= `CVF_RST_UV_THR;
            undervolt_recovery_mode_r <= `CVF_RST_UNDERVOLT_RECOVERY_MODE;
        end else if (do_write && wstrb0_r && addr_hit(awaddr_r)) begin
            case (addr_idx(awaddr_r)) // R16
                `CVF_IDX_OV_TRIP: ov_trip_r <= wdata_r[7:0] & `CVF_MASK_OV_TRIP;
                `CVF_IDX_OV_CFG: ov_cfg_r <= wdata_r[7:0] & `CVF_MASK_OV_CFG;
                `CVF_IDX_UV_THR: uv_thr_r <= wdata_r[7:0] & `CVF_MASK_UV_THR;
                `CVF_IDX_UNDERVOLT_RECOVERY_MODE: undervolt_recovery_mode_r <= wdata_r[7:0] & `CVF_MASK_UNDERVOLT_RECOVERY_MODE;
                default: ov_trip_r <= ov_trip_r;
            endcase
        end
    end

    // ==========
    // axi4-lite read channel
    wire [7:0] status_w;
    reg [7:0] rd_val;
    reg rd_known;

    assign s_axil_arready = !s_axil_rvalid;
    assign status_w = {2'b00, thermistor_line_oe, discharge_switch_en, charge_switch_en,
        shutdown_req, undervolt_fault, overvolt_fault};

    always @* begin
        rd_val = 8'h00;
        rd_known = addr_hit(s_axil_araddr);
        case (addr_idx(s_axil_araddr))
            `CVF_IDX_OV_TRIP: rd_val = ov_trip_r;
            `CVF_IDX_OV_CFG: rd_val = ov_cfg_r;
            `CVF_IDX_UV_THR: rd_val = uv_thr_r;
            `CVF_IDX_UNDERVOLT_RECOVERY_MODE: rd_val = undervolt_recovery_mode_r;
            `CVF_IDX_STATUS: rd_val = status_w;
            default: rd_known = 1'b0;
        endcase
        if (!rd_known) begin
            rd_val = 8'h00;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= 2'b00;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= {24'h00_0000, rd_val};
            s_axil_rresp <= rd_known ? 2'b00 : 2'b10;
        end else if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end

    // ==========
    // thresholds
    wire [`CVF_MV_W-1:0] ov_trip_w;
    wire [`CVF_MV_W-1:0] ov_rel_w;
    wire [`CVF_MV_W-1:0] uv_trip_w;
    wire [`CVF_MV_W-1:0] uv_sum_w;
    wire [`CVF_MV_W-1:0] undervolt_recovery_mode_w;
    wire [7:0] ov_dly_ticks;
    wire [7:0] uv_dly_ticks;
    wire uv_off;

    assign ov_trip_w = ov_trip_mv(ov_trip_r[5:0]);
    assign ov_rel_w = ov_trip_w - ov_hyst_mv(ov_cfg_r[`CVF_OV_HYST_MSB:`CVF_OV_HYST_LSB]); // R14
    assign uv_trip_w = uv_trip_mv(uv_thr_r[`CVF_UV_TRIP_MSB:`CVF_UV_TRIP_LSB]);
    assign uv_sum_w = uv_trip_w + uv_hyst_mv(undervolt_recovery_mode_r[`CVF_UV_HYST_MSB:`CVF_UV_HYST_LSB]);
    assign undervolt_recovery_mode_w = uv_thr_r[`CVF_UV_BYPASS_BIT] ? uv_trip_w : // R4
        ((uv_sum_w > `CVF_UNDERVOLT_RECOVERY_MODE_MAX_MV) ? `CVF_UNDERVOLT_RECOVERY_MODE_MAX_MV : uv_sum_w); // R11
    assign ov_dly_ticks = `CVF_OV_DLY_BASE_TICKS +
        {5'h00, ov_cfg_r[`CVF_OV_DLY_MSB:`CVF_OV_DLY_LSB]}; // R3
    assign uv_off = (undervolt_recovery_mode_r[`CVF_UV_DLY_MSB:`CVF_UV_DLY_LSB] == `CVF_UV_DLY_OFF); // R12
    assign uv_dly_ticks = `CVF_UV_DLY_BASE_TICKS <<
        undervolt_recovery_mode_r[`CVF_UV_DLY_MSB:`CVF_UV_DLY_LSB]; // R12

    // ==========
    // cell comparisons
    wire ov_any_above;
    wire ov_all_below;
    wire uv_any_below;
    wire rec_all_above;
    wire rec_any_below;

    cvf_cell_compare u_cmp_ov_trip (
        .cell_mv(cell_mv), .cell_enable(cell_enable), .threshold(ov_trip_w),
        .any_above(ov_any_above), .all_above(), .any_below(), .all_below()
    );
    cvf_cell_compare u_cmp_ov_rel (
        .cell_mv(cell_mv), .cell_enable(cell_enable), .threshold(ov_rel_w),
        .any_above(), .all_above(), .any_below(), .all_below(ov_all_below)
    );
    cvf_cell_compare u_cmp_uv_trip (
        .cell_mv(cell_mv), .cell_enable(cell_enable), .threshold(uv_trip_w),
        .any_above(), .all_above(), .any_below(uv_any_below), .all_below()
    );
    cvf_cell_compare u_cmp_undervolt_recovery_mode (
        .cell_mv(cell_mv), .cell_enable(cell_enable), .threshold(undervolt_recovery_mode_w),
        .any_above(), .all_above(rec_all_above), .any_below(rec_any_below), .all_below()
    );

    // ==========
    // delay timers
    localparam [1:0] UV_NORMAL = 2'b00;
    localparam [1:0] UV_FAULT = 2'b01;
    localparam [1:0] UV_SHUTDOWN = 2'b10;
    reg [1:0] uv_state_r;
    reg [1:0] uv_state_nxt;
    wire ov_expired;
    wire uv_expired;
    wire sd_expired;
    wire sd_run;

    cvf_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr_ov (
        .aclk(aclk), .aresetn(aresetn), .run(ov_any_above && !overvolt_fault),
        .target(ov_dly_ticks), .expired(ov_expired)
    );
    cvf_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr_uv (
        .aclk(aclk), .aresetn(aresetn),
        .run(uv_any_below && !uv_off && (uv_state_r == UV_NORMAL)), // R15
        .target(uv_dly_ticks), .expired(uv_expired)
    );
    assign sd_run = (uv_state_r == UV_FAULT) && undervolt_recovery_mode_r[`CVF_UV_SD_BIT] && rec_any_below; // R9
    cvf_delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr_sd (
        .aclk(aclk), .aresetn(aresetn), .run(sd_run),
        .target(`CVF_SD_TICKS), .expired(sd_expired)
    );

    // ==========
    // fault state
    always @* begin
        uv_state_nxt = uv_state_r;
        case (uv_state_r)
            UV_NORMAL: begin
                if (uv_expired) begin
                    uv_state_nxt = UV_FAULT; // R15
                end
            end
            UV_FAULT: begin
                if (sd_expired) begin
                    uv_state_nxt = UV_SHUTDOWN; // R9 R8
                end else if (rec_all_above &&
                        (!undervolt_recovery_mode_r[`CVF_UV_MODE_BIT] || !load_present)) begin
                    uv_state_nxt = UV_NORMAL; // R6 R7
                end
            end
            UV_SHUTDOWN: uv_state_nxt = UV_SHUTDOWN;
            default: uv_state_nxt = UV_NORMAL;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            uv_state_r <= UV_NORMAL;
            overvolt_fault <= 1'b0;
        end else begin
            uv_state_r <= uv_state_nxt;
            if (!overvolt_fault && ov_expired) begin
                overvolt_fault <= 1'b1; // R14
            end else if (overvolt_fault && ov_all_below) begin
                overvolt_fault <= 1'b0; // R14
            end
        end
    end

    // ==========
    // outputs
    assign thermistor_line_o = 1'b0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            undervolt_fault <= 1'b0;
            shutdown_req <= 1'b0;
            charge_switch_en <= 1'b0;
            discharge_switch_en <= 1'b0;
            thermistor_line_oe <= 1'b0;
        end else begin
            undervolt_fault <= (uv_state_nxt == UV_FAULT);
            shutdown_req <= (uv_state_nxt == UV_SHUTDOWN);
            // charge switch returns with the same edge as recovery
            charge_switch_en <= (uv_state_nxt == UV_NORMAL) && !overvolt_fault &&
                !(!overvolt_fault && ov_expired); // R6
            discharge_switch_en <= (uv_state_nxt == UV_NORMAL);
            thermistor_line_oe <= ov_cfg_r[`CVF_OV_PULL_BIT] && (overvolt_fault ?
                !ov_all_below : ov_expired); // R1
        end
    end
endmodule

/* cvf_fault_asserts.sv */
// assertions on the ports of the cell voltage fault block
`timescale 1ns/1ps
`include "cvf_consts.vh"
module cvf_fault_asserts #(
    parameter [31:0] TICK_CYCLES = 32'h0000_0004
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axil_bready,
    input wire [1:0] s_axil_bresp,
    input wire s_axil_bvalid,
    input wire s_axil_rready,
    input wire [31:0] s_axil_rdata,
    input wire s_axil_rvalid,
    input wire [`CVF_CELLS*`CVF_MV_W-1:0] cell_mv,
    input wire [`CVF_CELLS-1:0] cell_enable,
    input wire overvolt_fault,
    input wire undervolt_fault,
    input wire shutdown_req,
    input wire charge_switch_en,
    input wire discharge_switch_en,
    input wire thermistor_line_oe
);
    // ==========
    // cell summaries
    logic [`CVF_CELLS-1:0] hi, lo, rec_ok, ov_ok;
    logic [31:0] hi_cnt, lo_cnt;
    always_comb begin
        for (int i = 0; i < `CVF_CELLS; i++) begin
            hi[i] = cell_enable[i] && (cell_mv[13*i +: 13] > `CVF_OV_BASE_MV);
            lo[i] = cell_enable[i] && (cell_mv[13*i +: 13] < 13'h0b54);
            rec_ok[i] = !cell_enable[i] || (cell_mv[13*i +: 13] > `CVF_UV_BASE_MV);
            ov_ok[i] = !cell_enable[i] || (cell_mv[13*i +: 13] < 13'h1117);
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt <= 32'h0000_0000;
            lo_cnt <= 32'h0000_0000;
        end else begin
            hi_cnt <= (|hi) ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
            lo_cnt <= (|lo) ? lo_cnt + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pull_needs_ov: assert property (thermistor_line_oe |-> overvolt_fault)
        else $error("thermistor pull without overvoltage fault");
    a_ov_full_delay: assert property (
        $rose(overvolt_fault) |-> hi_cnt >= 2 * TICK_CYCLES)
        else $error("overvoltage fault before its delay");
    a_ov_clear_low: assert property ($fell(overvolt_fault) |-> $past(&ov_ok))
        else $error("overvoltage fault cleared with a cell high");
    a_uv_full_delay: assert property (
        $rose(undervolt_fault) |-> lo_cnt >= 2 * TICK_CYCLES)
        else $error("undervoltage fault before its delay");
    a_uv_recover_hi: assert property (
        $fell(undervolt_fault) && !shutdown_req |-> $past(&rec_ok))
        else $error("undervoltage recovery with a cell low");
    a_uv_fets_off: assert property (
        undervolt_fault |-> !charge_switch_en && !discharge_switch_en)
        else $error("switches on during undervoltage fault");
    a_ov_chg_off: assert property (overvolt_fault |-> !charge_switch_en)
        else $error("charge switch on during overvoltage fault");
    a_sd_from_uv: assert property ($rose(shutdown_req) |-> $past(undervolt_fault))
        else $error("shutdown outside undervoltage fault");
    a_sd_sticky: assert property (shutdown_req |=> shutdown_req)
        else $error("shutdown request dropped");
    a_bresp_hold: assert property (
        s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response not held");
    a_rdata_hold: assert property (
        s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data not held");
    a_rsvd_zero: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h00_0000)
        else $error("upper read data bits not zero");
    c_ov: cover property ($rose(overvolt_fault));
    c_uv: cover property ($rose(undervolt_fault));
    c_sd: cover property ($rose(shutdown_req));
    c_pull: cover property ($rose(thermistor_line_oe));
endmodule

/* cvf_pack_model.sv */
// battery cells, charger and load facing the fault block
`timescale 1ns/1ps
`include "cvf_consts.vh"
module cvf_pack_model (
    output logic [`CVF_CELLS*`CVF_MV_W-1:0] cell_mv,
    output logic [`CVF_CELLS-1:0] cell_enable,
    output logic charger_present,
    output logic load_present
);
    // ==========
    // top cell is not fitted and sits at zero
    initial begin
        cell_mv = '0;
        for (int i = 0; i < `CVF_CELLS - 1; i++) cell_mv[13*i +: 13] = 13'h0a8c;
        cell_enable = 10'h1ff;
        charger_present = 1'b1;
        load_present = 1'b0;
    end
    task set_all(input int mv);
        for (int i = 0; i < `CVF_CELLS - 1; i++) cell_mv[13*i +: 13] <= mv[12:0];
    endtask
    task set_one(input int i, input int mv);
        cell_mv[13*i +: 13] <= mv[12:0];
    endtask
    task set_load(input logic b);
        load_present <= b;
    endtask
endmodule

/* cell_voltage_fault_config_bench.sv */
// testbench for the cell voltage fault block
`timescale 1ns/1ps
`include "cvf_consts.vh"
module cell_voltage_fault_config_bench;
    localparam int TK = 4;
    reg aclk = 1'b0, aresetn = 1'b0;
    reg [31:0] s_axil_awaddr = '0, s_axil_wdata = '0, s_axil_araddr = '0;
    reg [3:0] s_axil_wstrb = 4'hf;
    reg s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    reg s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
    wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    wire [1:0] s_axil_bresp, s_axil_rresp;
    wire [31:0] s_axil_rdata;
    wire [`CVF_CELLS*`CVF_MV_W-1:0] cell_mv;
    wire [`CVF_CELLS-1:0] cell_enable;
    wire charger_present, load_present, overvolt_fault, undervolt_fault, shutdown_req;
    wire charge_switch_en, discharge_switch_en, thermistor_line_o, thermistor_line_oe;
    wire thermistor_line_i = thermistor_line_oe ? thermistor_line_o : 1'b1;
    int miscompares = 0, check_count = 0;
    int t, tr, hy, d, n, rc;
    reg [31:0] lf = 32'h0000_f85d;
    logic [7:0] mk[4] = '{8'h3f, 8'hf7, 8'h8f, 8'hf7};

    cvf_fault_core #(.TICK_CYCLES(TK)) dut (.*);
    cvf_pack_model pk (.*);
    always #2.5 aclk = ~aclk;

    // ==========
    // helpers
    function automatic [31:0] lfsr();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function automatic logic flag(input int s);
        return (s == 0) ? overvolt_fault : (s == 1) ? undervolt_fault : shutdown_req;
    endfunction
    task print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task lapse(input int k);
        if (k > 0) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task axw(input [7:0] idx, input [7:0] dt, input [1:0] er);
        @(posedge aclk);
        s_axil_awaddr <= {22'h0, idx, 2'b00};
        s_axil_wdata <= {24'h0, dt};
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
            lapse(++n > 50);
        end while (s_axil_bvalid !== 1'b1);
        s_axil_bready <= 1'b0;
        check(s_axil_bresp, er);
    endtask
    task axr(input [7:0] idx, input [7:0] ed, input [1:0] er);
        @(posedge aclk);
        s_axil_araddr <= {22'h0, idx, 2'b00};
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
            lapse(++n > 50);
        end while (s_axil_rvalid !== 1'b1);
        s_axil_rready <= 1'b0;
        check(s_axil_rdata, {24'h0, ed});
        check(s_axil_rresp, er);
    endtask
    task waitf(input int s, input int lim);
        n = 0;
        while (flag(s) !== 1'b1) begin
            @(posedge aclk);
            lapse(++n > lim);
        end
    endtask

    // ==========
    // main sequence
    initial begin
        do_reset();
        axr(8'h10, 8'h18, 2'b00);
        for (int i = 0; i < 4; i++) begin
            axr(i + 2, 8'h00, 2'b00);
            axw(i + 2, 8'hff, 2'b00);
            axr(i + 2, mk[i], 2'b00);
            axw(i + 2, 8'h00, 2'b00);
        end
        s_axil_wstrb <= 4'he;
        axw(8'h03, 8'h11, 2'b00);
        axr(8'h03, 8'h00, 2'b00);
        s_axil_wstrb <= 4'hf;
        axw(8'h07, 8'h55, 2'b10);
        axr(8'h07, 8'h00, 2'b10);
        axw(8'h10, 8'hff, 2'b00);
        axr(8'h10, 8'h18, 2'b00);
        for (int c = 0; c < 8; c++) begin
            t = lfsr() % 64;
            tr = 2800 + 25 * t;
            hy = (c == 6) ? 25 : (c == 7) ? 0 : 300 - 50 * c;
            d = TK * (2 + c);
            axw(8'h02, t[7:0], 2'b00);
            axw(8'h03, {c[0], c[2:0], 1'b0, c[2:0]}, 2'b00);
            @(posedge aclk);
            pk.set_one(c, tr + 1);
            waitf(0, 200);
            check(n >= d && n <= d + 3, 1);
            check(thermistor_line_oe, c[0]);
            check(thermistor_line_i, !c[0]);
            axr(8'h10, {2'b00, c[0], 5'h11}, 2'b00);
            @(posedge aclk);
            pk.set_one(c, tr - hy);
            repeat (3) @(posedge aclk);
            check(overvolt_fault, 1);
            pk.set_one(c, tr - hy - 1);
            repeat (3) @(posedge aclk);
            check({overvolt_fault, thermistor_line_oe}, 0);
            pk.set_one(c, 2700);
        end
        axw(8'h02, 8'h3f, 2'b00);
        @(posedge aclk);
        pk.set_all(3000);
        pk.set_load(1'b1);
        for (int k = 0; k < 4; k++) begin
            t = lfsr() % 16 | (k & 2) << 2;
            tr = 1400 + 100 * t;
            rc = (tr + 400 * (k + 1) > 3500) ? 3500 : tr + 400 * (k + 1);
            rc = (k == 3) ? tr : rc;
            d = TK * (2 << k);
            axw(8'h04, {k == 3, 3'b000, t[3:0]}, 2'b00);
            axw(8'h05, {k[0], 1'b0, k[1:0], 1'b0, k[2:0]}, 2'b00);
            @(posedge aclk);
            pk.set_one(k, tr - 1);
            repeat (d - 2) @(posedge aclk);
            pk.set_one(k, 3000);
            repeat (2) @(posedge aclk);
            check(undervolt_fault, 0);
            pk.set_one(k, tr - 1);
            waitf(1, 300);
            check(n >= d && n <= d + 3, 1);
            check({charge_switch_en, discharge_switch_en}, 0);
            if (k == 0) begin
                repeat (150) @(posedge aclk);
                check(shutdown_req, 0);
            end
            pk.set_all(rc);
            repeat (4) @(posedge aclk);
            check(undervolt_fault, 1);
            pk.set_all(rc + 1);
            repeat (4) @(posedge aclk);
            check(undervolt_fault, k[0]);
            pk.set_load(1'b0);
            repeat (3) @(posedge aclk);
            check({undervolt_fault, charge_switch_en, discharge_switch_en}, 3'b011);
            pk.set_all(3000);
            pk.set_load(1'b1);
        end
        axw(8'h05, 8'h47, 2'b00);
        @(posedge aclk);
        pk.set_one(0, 1300);
        repeat (100) @(posedge aclk);
        check(undervolt_fault, 0);
        axw(8'h05, 8'h40, 2'b00);
        waitf(1, 60);
        waitf(2, 300);
        check(n > 32 * TK && n <= 32 * TK + 4, 1);
        repeat (3) @(posedge aclk);
        check({shutdown_req, undervolt_fault}, 2'b10);
        pk.set_all(3000);
        do_reset();
        axr(8'h10, 8'h18, 2'b00);
        axr(8'h05, 8'h00, 2'b00);
        print_verdict();
    end
endmodule

bind cvf_fault_core cvf_fault_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
